// ==== adc_serial_readout_regs.sv ====
// Serial readout, command decoder and configuration registers of the converter
`timescale 1ns/1ns

module adc_serial_readout_regs
  import adc_readout_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID_VALUE = 8'h05  // Arbitrary value
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        cs_n_pin,
  input  wire logic        sclk_pin,
  input  wire logic        din_pin,
  output logic             combined_out_ready_line_out,
  output logic             combined_out_ready_line_oe,
  output logic             data_ready_pin_n,
  input  wire logic        result_valid,
  input  wire logic [23:0] result_data,
  output logic             result_ready,
  input  wire logic        conversion_active,
  input  wire logic [6:0]  fault_flags,
  output logic             filter_restart
);

  // ==========================================================================
  // Helper functions
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction : crc8

  function automatic logic [4:0] frame_len(input logic [7:0] system_control);
    return RESULT_BYTES + {4'h0, system_control[SYS_STATUS_PREFIX_BIT]} + {4'h0, system_control[SYS_CRC_BIT]};
  endfunction : frame_len

  function automatic logic [7:0] reg_value(input logic [5:0] addr,
                                           input logic [17:0][7:0] regs);
    if (addr >= REG_COUNT) begin
      return 8'h00;
    end else if (addr[4:0] == ADDR_DEVICE_IDENTITY) begin
      return DEVICE_ID_VALUE;
    end else if (addr[4:0] == ADDR_DEVICE_FLAGS) begin
      return {regs[ADDR_DEVICE_FLAGS][FLAGS_POR_BIT], fault_flags};
    end else begin
      return regs[addr[4:0]];
    end
  endfunction : reg_value

  function automatic logic [7:0] frame_byte(input logic [4:0] idx,
                                            input state_type st);
    logic [7:0] system_control;
    logic [4:0] k;
    system_control = st.regs[ADDR_SYSTEM_CONTROL];
    k   = idx - {4'h0, system_control[SYS_STATUS_PREFIX_BIT]};
    if (system_control[SYS_STATUS_PREFIX_BIT] && idx == 5'h00) begin
      return reg_value({1'b0, ADDR_DEVICE_FLAGS}, st.regs);
    end else if (k == 5'h00) begin
      return st.hold[23:16];
    end else if (k == 5'h01) begin
      return st.hold[15:8];
    end else if (k == 5'h02) begin
      return st.hold[7:0];
    end else begin
      return crc8(st.hold);
    end
  endfunction : frame_byte

  function automatic logic [7:0] restart_mask(input logic [4:0] addr);
    case (addr)
      ADDR_INPUT_SELECT:         return RESTART_MASK_FULL;
      ADDR_AMPLIFIER_SETUP:      return RESTART_MASK_FULL;
      ADDR_RATE_FILTER_SETUP:    return RESTART_MASK_FULL;
      ADDR_REFERENCE_CONTROL:    return RESTART_MASK_REF;
      ADDR_EXCITATION_MAGNITUDE: return RESTART_MASK_MAG;
      ADDR_EXCITATION_ROUTING:   return RESTART_MASK_FULL;
      ADDR_SYSTEM_CONTROL:       return RESTART_MASK_SYS;
      default:                   return 8'h00;
    endcase
  endfunction : restart_mask

  // ==========================================================================
  // State
  state_type  q;
  state_type  s;
  logic [7:0] rxb;
  logic [7:0] nb;
  logic [7:0] old_val;
  logic [5:0] waddr;
  logic [4:0] flen;
  logic       pop;
  logic       push;
  logic       sel;
  logic       cs_fall;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       din_bit;

  always_comb begin
    s         = q;
    s.restart = 1'b0;
    rxb       = 8'h00;
    nb        = 8'h00;
    old_val   = 8'h00;
    waddr     = 6'h00;
    flen      = frame_len(q.regs[ADDR_SYSTEM_CONTROL]);

    // Three-stage pin sampling; a level counts once stages two and three agree
    s.cs.sync   = {q.cs.sync[1:0], cs_n_pin};
    s.sclk.sync = {q.sclk.sync[1:0], sclk_pin};
    s.din.sync  = {q.din.sync[1:0], din_pin};
    if (q.cs.sync[1] == q.cs.sync[2]) begin
      s.cs.filt = q.cs.sync[2];
    end
    if (q.sclk.sync[1] == q.sclk.sync[2]) begin
      s.sclk.filt = q.sclk.sync[2];
    end
    if (q.din.sync[1] == q.din.sync[2]) begin
      s.din.filt = q.din.sync[2];
    end
    cs_fall   = q.cs.filt & ~s.cs.filt;
    sel       = ~s.cs.filt;
    sclk_rise = sel & ~q.sclk.filt & s.sclk.filt;
    sclk_fall = sel & q.sclk.filt & ~s.sclk.filt;
    din_bit   = s.din.filt;

    // Deselect ends any command and any partial byte
    if (!sel) begin
      s.bit_cnt = 3'h0;
      s.dec     = dec_cmd;
      if (q.mode == mode_regread || q.mode == mode_result) begin
        s.mode = mode_idle;
      end
    end

    if (cs_fall) begin
      s.out_bit = ~q.pending;
    end

    // Output bits change on the rising clock; a new byte loads at bit zero
    if (sclk_rise && q.mode != mode_idle) begin
      if (q.bit_cnt == 3'h0) begin
        if (q.mode == mode_regread) begin
          nb = reg_value({1'b0, q.base} + {1'b0, q.idx}, q.regs);
        end else begin
          nb = frame_byte(q.idx, q);
        end
        s.out_sr  = nb;
        s.out_bit = nb[7];
      end else begin
        s.out_bit = q.out_sr[3'h7 - q.bit_cnt];
      end
    end

    // Input bits are taken on the falling clock
    if (sclk_fall) begin
      s.pending = 1'b0;
      s.rx_sr   = {q.rx_sr[6:0], din_bit};
      s.bit_cnt = q.bit_cnt + 3'h1;
      if (q.bit_cnt == 3'h7) begin
        rxb = {q.rx_sr[6:0], din_bit};
        case (q.mode)
          mode_direct, mode_result: begin
            s.idx = (q.idx == flen - 5'h01) ? 5'h00 : q.idx + 5'h01;
          end
          mode_regread: begin
            if (q.idx == q.count) begin
              s.mode = mode_idle;
              s.dec  = dec_cmd;
            end else begin
              s.idx = q.idx + 5'h01;
            end
          end
          default: begin
          end
        endcase
        // Decoding runs alongside direct and result readback; a register readback holds it in dec_rd_busy
        case (q.dec)
          dec_cmd: begin
            if (rxb == CMD_READ_RESULT) begin
              s.mode = mode_result;
              s.idx  = 5'h00;
            end else if (rxb[7:5] == OPC_REGISTER_READ) begin
              s.base = rxb[4:0];
              s.dec  = dec_rd_count;
            end else if (rxb[7:5] == OPC_REGISTER_WRITE) begin
              s.base = rxb[4:0];
              s.dec  = dec_wr_count;
            end
          end
          dec_rd_count: begin
            s.count = rxb[4:0];
            s.mode  = mode_regread;
            s.idx   = 5'h00;
            s.dec   = dec_rd_busy;
          end
          dec_rd_busy: begin
          end
          dec_wr_count: begin
            s.count  = rxb[4:0];
            s.wr_idx = 5'h00;
            s.dec    = dec_wr_data;
          end
          dec_wr_data: begin
            // Output mode and index are left alone here
            waddr   = {1'b0, q.base} + {1'b0, q.wr_idx};
            old_val = q.regs[waddr[4:0]];
            if (waddr < REG_COUNT) begin
              if (waddr[4:0] == ADDR_DEVICE_FLAGS) begin
                s.regs[ADDR_DEVICE_FLAGS][FLAGS_POR_BIT] = rxb[FLAGS_POR_BIT];
              end else if (waddr[4:0] != ADDR_DEVICE_IDENTITY) begin
                s.regs[waddr[4:0]] = rxb;
              end
              if (conversion_active && ((old_val ^ rxb) & restart_mask(waddr[4:0])) != 8'h00) begin
                s.restart = 1'b1;
              end
            end
            if (q.wr_idx == q.count) begin
              s.dec = dec_cmd;
            end else begin
              s.wr_idx = q.wr_idx + 5'h01;
            end
          end
          default: begin
            s.dec = dec_cmd;
          end
        endcase
      end
    end

    // ========================================================================
    // Two-entry result buffer; held while a command readback owns the output
    push = result_valid && (q.fifo_cnt != 2'h2);
    pop  = (q.fifo_cnt != 2'h0) && (q.mode != mode_regread) && (q.mode != mode_result)
           && (s.mode != mode_regread) && (s.mode != mode_result);
    if (pop) begin
      s.hold    = q.fifo[q.rd_ptr].data;
      s.rd_ptr  = ~q.rd_ptr;
      s.pending = 1'b1;
      s.mode    = mode_direct;
      s.idx     = 5'h00;
      s.out_bit = 1'b0;
    end
    if (push) begin
      s.fifo[q.wr_ptr].data = result_data;
      s.wr_ptr              = ~q.wr_ptr;
    end
    s.fifo_cnt = q.fifo_cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q           <= '0;
      q.cs        <= '1;
      q.regs      <= REG_DEFAULTS;
      q.mode      <= mode_idle;
      q.dec       <= dec_cmd;
      q.out_bit   <= 1'b1;
    end else begin
      q <= s;
    end
  end

  // ==========================================================================
  // Outputs
  assign combined_out_ready_line_out = q.out_bit;
  assign combined_out_ready_line_oe  = ~q.cs.filt;
  assign data_ready_pin_n            = ~q.pending;
  assign result_ready                = (q.fifo_cnt != 2'h2);
  assign filter_restart              = q.restart;

  // ==========================================================================
  // Assertions
  deselect_float_a: assert property (@(posedge sys_clk) disable iff (reset)
    cs_n_pin [*6] |-> !combined_out_ready_line_oe)
    else $error("Combined line driven while deselected");

  ready_low_both_a: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(data_ready_pin_n) |-> !combined_out_ready_line_out)
    else $error("Combined line not low with ready pin");

  select_shows_a: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(q.cs.filt) && !$past(pop) |-> combined_out_ready_line_out == !$past(q.pending))
    else $error("Wrong level on chip select fall");

  restart_cause_a: assert property (@(posedge sys_clk) disable iff (reset)
    filter_restart |-> $past(conversion_active) && $past(q.dec) == dec_wr_data)
    else $error("Restart without running conversion or write");

  fifo_count_a: assert property (@(posedge sys_clk) disable iff (reset)
    result_valid && result_ready && !pop |=> q.fifo_cnt == $past(q.fifo_cnt) + 2'h1)
    else $error("Buffer lost a pushed word");

  byte_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    s.cs.filt |=> q.bit_cnt == 3'h0 && q.dec == dec_cmd)
    else $error("Partial byte kept after deselect");

  frame_wrap_a: assert property (@(posedge sys_clk) disable iff (reset)
    q.mode == mode_direct |-> q.idx < frame_len(q.regs[ADDR_SYSTEM_CONTROL]))
    else $error("Frame index beyond frame");

  regread_start_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(q.mode == mode_regread) |-> q.idx == 5'h00 && q.bit_cnt == 3'h0)
    else $error("Register readback not aligned");

  reset_defaults_a: assert property (@(posedge sys_clk)
    reset |=> q.regs == REG_DEFAULTS)
    else $error("Registers not at defaults after reset");

  ready_drop_a: assert property (@(posedge sys_clk) disable iff (reset)
    pop |=> !data_ready_pin_n && !combined_out_ready_line_out)
    else $error("New result did not lower both ready outputs");

  ready_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    sclk_fall && !pop |=> data_ready_pin_n)
    else $error("Ready pin not released on clock fall");

  write_keeps_mode_a: assert property (@(posedge sys_clk) disable iff (reset)
    q.dec == dec_wr_data && sclk_fall && q.bit_cnt == 3'h7 && !pop |=> q.mode == $past(q.mode))
    else $error("Register write disturbed the readback");

  block_write_a: assert property (@(posedge sys_clk) disable iff (reset)
    q.dec == dec_wr_data && sclk_fall && q.bit_cnt == 3'h7 && waddr < REG_COUNT
      && waddr > 6'h01 |=> q.regs[$past(waddr)] == $past(rxb))
    else $error("Written byte not applied at once");

  result_start_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(q.mode == mode_result) |-> q.idx == 5'h00 && q.bit_cnt == 3'h0)
    else $error("Result readback not aligned");

  restart_single_a: assert property (@(posedge sys_clk) disable iff (reset)
    filter_restart |=> !filter_restart)
    else $error("Restart pulse longer than one cycle");

  readback_stall_a: assert property (@(posedge sys_clk) disable iff (reset)
    q.mode == mode_regread || q.mode == mode_result |-> !pop)
    else $error("Held result replaced during command readback");

  regread_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
    sclk_rise && q.mode == mode_regread && q.bit_cnt == 3'h0
      && ({1'b0, q.base} + {1'b0, q.idx}) >= REG_COUNT |=> q.out_sr == 8'h00)
    else $error("Read beyond last register not zero");

  frame_repeat_a: assert property (@(posedge sys_clk) disable iff (reset)
    q.mode == mode_direct && sclk_fall && q.bit_cnt == 3'h7 && q.idx == flen - 5'h01
      && !pop |=> q.idx == 5'h00)
    else $error("Frame did not restart at first byte");

endmodule : adc_serial_readout_regs

// ==== adc_readout_pkg.sv ====
// Constants and types shared by the converter serial readout and register logic
package adc_readout_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [5:0] REG_COUNT                 = 6'h12;
  localparam logic [4:0] ADDR_DEVICE_IDENTITY      = 5'h00;
  localparam logic [4:0] ADDR_DEVICE_FLAGS         = 5'h01;
  localparam logic [4:0] ADDR_INPUT_SELECT         = 5'h02;
  localparam logic [4:0] ADDR_AMPLIFIER_SETUP      = 5'h03;
  localparam logic [4:0] ADDR_RATE_FILTER_SETUP    = 5'h04;
  localparam logic [4:0] ADDR_REFERENCE_CONTROL    = 5'h05;
  localparam logic [4:0] ADDR_EXCITATION_MAGNITUDE = 5'h06;
  localparam logic [4:0] ADDR_EXCITATION_ROUTING   = 5'h07;
  localparam logic [4:0] ADDR_BIAS_VOLTAGE_SELECT  = 5'h08;
  localparam logic [4:0] ADDR_SYSTEM_CONTROL       = 5'h09;
  localparam logic [4:0] ADDR_OFFSET_TRIM_LOW      = 5'h0a;
  localparam logic [4:0] ADDR_OFFSET_TRIM_MID      = 5'h0b;
  localparam logic [4:0] ADDR_OFFSET_TRIM_HIGH     = 5'h0c;
  localparam logic [4:0] ADDR_GAIN_TRIM_LOW        = 5'h0d;
  localparam logic [4:0] ADDR_GAIN_TRIM_MID        = 5'h0e;
  localparam logic [4:0] ADDR_GAIN_TRIM_HIGH       = 5'h0f;
  localparam logic [4:0] ADDR_GENERAL_IO_DIR_DATA  = 5'h10;
  localparam logic [4:0] ADDR_GENERAL_IO_CONFIG    = 5'h11;

  // ==========================================================================
  // Reset values, highest address first; identity is supplied live
  localparam logic [17:0][7:0] REG_DEFAULTS = {
    8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10,
    8'h00, 8'hff, 8'h00, 8'h10, 8'h14, 8'h00, 8'h01, 8'h80, 8'h00};

  // ==========================================================================
  // Field positions and restart masks
  localparam int         SYS_STATUS_PREFIX_BIT = 0;
  localparam int         SYS_CRC_BIT       = 1;
  localparam int         FLAGS_POR_BIT     = 7;
  localparam logic [7:0] RESTART_MASK_FULL = 8'hff;
  localparam logic [7:0] RESTART_MASK_REF  = 8'h3f;
  localparam logic [7:0] RESTART_MASK_MAG  = 8'h0f;
  localparam logic [7:0] RESTART_MASK_SYS  = 8'he0;

  // ==========================================================================
  // Commands and framing
  localparam logic [7:0] CMD_READ_RESULT    = 8'h12;
  localparam logic [2:0] OPC_REGISTER_READ  = 3'h1;
  localparam logic [2:0] OPC_REGISTER_WRITE = 3'h2;
  localparam logic [7:0] CRC_POLY           = 8'h07;
  localparam logic [4:0] RESULT_BYTES       = 5'h03;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {mode_idle, mode_direct, mode_result, mode_regread} out_mode_type;
  typedef enum logic [2:0] {dec_cmd, dec_rd_count, dec_rd_busy, dec_wr_count, dec_wr_data}
    dec_state_type;

  typedef struct packed {
    logic [2:0] sync;
    logic       filt;
  } pin_sync_type;

  typedef struct packed {
    logic [23:0] data;
  } result_word_type;

  typedef struct packed {
    pin_sync_type          cs;
    pin_sync_type          sclk;
    pin_sync_type          din;
    out_mode_type          mode;
    dec_state_type         dec;
    logic [2:0]            bit_cnt;
    logic [7:0]            rx_sr;
    logic [7:0]            out_sr;
    logic                  out_bit;
    logic [4:0]            idx;
    logic [4:0]            base;
    logic [4:0]            count;
    logic [4:0]            wr_idx;
    logic                  pending;
    logic [23:0]           hold;
    logic [17:0][7:0]      regs;
    result_word_type [1:0] fifo;
    logic                  rd_ptr;
    logic                  wr_ptr;
    logic [1:0]            fifo_cnt;
    logic                  restart;
  } state_type;

endpackage : adc_readout_pkg

// ==== adc_host_model.sv ====
// Serial host model that drives the converter's chip select, clock and data pins
`timescale 1ns/1ns

module adc_host_model (
  input  wire logic line_level,
  output logic      cs_n_pin,
  output logic      sclk_pin,
  output logic      din_pin
);
  // ==========================================================================
  // Idle levels: clock stands low between frames
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    din_pin  = 1'b0;
  end

  // ==========================================================================
  // Select or deselect; the wait lets chip select clear the pin filter
  task automatic select(input logic on);
    cs_n_pin = ~on;
    #80;
  endtask : select

  // One byte, MSB first; line sampled late in the low phase, where it stands
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      din_pin  = tx[i];
      sclk_pin = 1'b1;
      #40;
      sclk_pin = 1'b0;
      #32;
      rx[i] = line_level;
      // Data line drops after the last fall, never in the next byte's time step
      if (i == 0) din_pin = 1'b0;
      #8;
    end
  endtask : xfer
endmodule : adc_host_model

// ==== adc_serial_readout_regs_bench.sv ====
// Self-checking bench for the converter serial readout and register block
`timescale 1ns/1ns

module adc_serial_readout_regs_bench;
  import adc_readout_pkg::*;

  // ==========================================================================
  // Signals
  localparam logic [7:0] ID_CODE = 8'h3c;  // Arbitrary identity value
  logic        sys_clk, reset, cs_n, sclk, din, line, last_q;
  logic        out, oe, rdy_n, res_valid, res_ready, conv_act, restart;
  logic [23:0] res_data;
  logic [6:0]  faults;
  logic [7:0]  rx, rbuf [0:18];
  int          mismatches, total_checks, restarts;

  adc_serial_readout_regs #(.DEVICE_ID_VALUE(ID_CODE)) dut_u (
    .sys_clk(sys_clk), .reset(reset), .cs_n_pin(cs_n), .sclk_pin(sclk), .din_pin(din),
    .combined_out_ready_line_out(out), .combined_out_ready_line_oe(oe),
    .data_ready_pin_n(rdy_n), .result_valid(res_valid), .result_data(res_data),
    .result_ready(res_ready), .conversion_active(conv_act), .fault_flags(faults),
    .filter_restart(restart));

  adc_host_model host_u (.line_level(line), .cs_n_pin(cs_n), .sclk_pin(sclk), .din_pin(din));

  // Released line shows the inverse of its last level, never a held value
  assign line = (oe === 1'b1) ? out : ~last_q;
  always @(posedge sys_clk) begin
    if (oe === 1'b1) last_q <= out;
    if (restart === 1'b1) restarts <= restarts + 1;
  end

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // Helpers
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8

  task automatic sel(input logic on);
    @(negedge sys_clk);
    host_u.select(on);
  endtask : sel

  task automatic rd_block(input logic [4:0] a, input int n);
    host_u.xfer({3'h1, a}, rx);
    host_u.xfer(8'(n - 1), rx);
    for (int i = 0; i < n; i++) host_u.xfer(8'h00, rbuf[i]);
  endtask : rd_block

  // Writes n bytes (1 or 2), upper byte of v first; selects around the frame
  task automatic wr(input logic [4:0] a, input logic [15:0] v, input int n);
    sel(1'b1);
    host_u.xfer({3'h2, a}, rx);
    host_u.xfer(8'(n - 1), rx);
    for (int i = n - 1; i >= 0; i--) host_u.xfer(v[8*i +: 8], rx);
    sel(1'b0);
  endtask : wr

  task automatic rd1(input logic [4:0] a, input logic [7:0] exp);
    sel(1'b1);
    rd_block(a, 1);
    sel(1'b0);
    check8(rbuf[0], exp);
  endtask : rd1

  task automatic push(input logic [23:0] w);
    @(negedge sys_clk);
    res_valid = 1'b1;
    res_data  = w;
    // Ready comes from a register, so its settled level at this edge holds to the next rise
    for (int i = 0; i < 2000 && res_ready !== 1'b1; i++) @(negedge sys_clk);
    @(negedge sys_clk);
    res_valid = 1'b0;
    repeat (8) @(negedge sys_clk);
  endtask : push

  function automatic logic [7:0] crc8(input logic [23:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction : crc8

  // ==========================================================================
  // Scenarios
  task automatic t_defaults;
    sel(1'b1);
    rd_block(5'h00, 19);
    sel(1'b0);
    check8(rbuf[0], ID_CODE);
    for (int i = 1; i < 18; i++) check8(rbuf[i], REG_DEFAULTS[i]);
    check8(rbuf[18], 8'h00);
  endtask : t_defaults

  task automatic t_writes;
    conv_act = 1'b1;
    restarts = 0;
    wr(ADDR_INPUT_SELECT, 16'h2305, 2);
    check8(8'(restarts), 8'h02);
    wr(ADDR_INPUT_SELECT, 16'h0023, 1);
    check8(8'(restarts), 8'h02);
    conv_act = 1'b0;
    wr(ADDR_AMPLIFIER_SETUP, 16'h0007, 1);
    check8(8'(restarts), 8'h02);
    wr(ADDR_DEVICE_IDENTITY, 16'h00aa, 1);
    rd1(ADDR_DEVICE_IDENTITY, ID_CODE);
    rd1(ADDR_INPUT_SELECT, 8'h23);
    rd1(ADDR_AMPLIFIER_SETUP, 8'h07);
  endtask : t_writes

  task automatic t_direct;
    check8({7'h00, oe}, 8'h00);
    push(24'ha5c381);
    check8({7'h00, rdy_n}, 8'h00);
    sel(1'b1);
    check8({7'h00, line}, 8'h00);
    for (int k = 0; k < 6; k++) begin
      host_u.xfer(8'h00, rx);
      check8(rx, 8'(24'ha5c381 >> (16 - 8 * (k % 3))));
    end
    check8({7'h00, rdy_n}, 8'h01);
    rd_block(ADDR_INPUT_SELECT, 1);
    check8(rbuf[0], 8'h23);
    sel(1'b0);
    sel(1'b1);
    check8({7'h00, line}, 8'h01);
    sel(1'b0);
  endtask : t_direct

  task automatic t_register_write_cmd_mid;
    push(24'h123456);
    sel(1'b1);
    host_u.xfer({3'h2, ADDR_INPUT_SELECT}, rx);
    check8(rx, 8'h12);
    host_u.xfer(8'h00, rx);
    check8(rx, 8'h34);
    host_u.xfer(8'h7e, rx);
    check8(rx, 8'h56);
    sel(1'b0);
    rd1(ADDR_INPUT_SELECT, 8'h7e);
  endtask : t_register_write_cmd_mid

  task automatic t_frame;
    wr(ADDR_SYSTEM_CONTROL, 16'h0013, 1);
    faults = 7'h05;
    sel(1'b1);
    host_u.xfer(CMD_READ_RESULT, rx);
    host_u.xfer(8'h00, rx);
    check8(rx, 8'h85);
    for (int k = 0; k < 3; k++) begin
      host_u.xfer(8'h00, rx);
      check8(rx, 8'(24'h123456 >> (16 - 8 * k)));
    end
    host_u.xfer(8'h00, rx);
    check8(rx, crc8(24'h123456));
    sel(1'b0);
    wr(ADDR_SYSTEM_CONTROL, 16'h0010, 1);
  endtask : t_frame

  // Two words arrive during a long register read; the buffer must refuse a third
  task automatic t_buffer;
    sel(1'b1);
    fork
      rd_block(5'h00, 19);
      begin
        // Let both command bytes pass so the words meet the register read
        #1400;
        push(24'h111111);
        push(24'h222222);
        check8({7'h00, res_ready}, 8'h00);
      end
    join
    sel(1'b0);
    check8(rbuf[5], REG_DEFAULTS[5]);
    check8({7'h00, res_ready}, 8'h01);
    sel(1'b1);
    host_u.xfer(CMD_READ_RESULT, rx);
    host_u.xfer(8'h00, rx);
    check8(rx, 8'h22);
    sel(1'b0);
  endtask : t_buffer

  // ==========================================================================
  // Run control
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  initial begin
    #400000;
    mismatches++;
    close_out();
  end

  initial begin
    reset = 1'b1;
    res_valid = 1'b0;
    res_data = 24'h000000;
    conv_act = 1'b0;
    faults = 7'h00;
    last_q = 1'b0;
    mismatches = 0;
    total_checks = 0;
    restarts = 0;
    repeat (4) @(negedge sys_clk);
    reset = 1'b0;
    repeat (8) @(negedge sys_clk);
    t_defaults();
    t_writes();
    t_direct();
    t_register_write_cmd_mid();
    t_frame();
    t_buffer();
    close_out();
  end
endmodule : adc_serial_readout_regs_bench
